/* File: rtl/ppc_counters.sv */
// Purpose: Performance counter bank behind an APB slave
// Assumes: Event inputs are single-cycle pulses synchronous to clk_sys
// Notes: Control word holds mode, clear and enable bits; unmapped reads give zero
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module ppc_counters
    import ppc_pkg::*;
#(
    parameter int W16 = 16,
    parameter int W8 = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events and status from the path logic
    input wire ppc_event_type events,
    input wire logic pointer_tracking_enable,
    input wire ppc_leak_type leak_offset
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] idx;
    logic access;
    logic wr_en;
    logic rd_en;
    logic rollover_select;
    logic clear_all_counters;
    logic [7:0] hi_hold_reg;

    assign idx = paddr[ADDR_LSB +: 8];
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign rd_en = access && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign rollover_select = ctrl_reg[CTRL_ROLLOVER_BIT];
    assign clear_all_counters = ctrl_reg[CTRL_CLEAR_BIT];

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && idx == IDX_CTRL) begin
            ctrl_reg <= pwdata[7:0];
        end else begin
            ctrl_reg[CTRL_CLEAR_BIT] <= 1'b0;
        end
    end

    // ************************************************************
    // Count enables and increments
    // ************************************************************
    logic [W16-1:0] b3_cnt_reg, fe_cnt_reg, prbs_cnt_reg, txf_cnt_reg, rxf_cnt_reg;
    logic [W8-1:0] blk_cnt_reg, pos_cnt_reg, neg_cnt_reg, ndf_cnt_reg;
    logic [3:0] fe_inc;
    logic ndf_code_ok;
    logic prbs_inc, txf_inc, rxf_inc, ndf_inc;

    always_comb begin
        fe_inc = 4'h0;
        if (ctrl_reg[CTRL_FAR_END_BLOCK_BIT]) begin
            fe_inc = {3'b000, events.far_end_block_err};
        end else if (events.far_end_valid && events.far_end_count >= FE_MIN
                     && events.far_end_count <= FE_MAX) begin
            fe_inc = events.far_end_count;
        end
    end

    always_comb begin
        unique case (events.new_data_flag_code)
            4'b1001, 4'b0001, 4'b1101, 4'b1011, 4'b1000: ndf_code_ok = 1'b1;
            default: ndf_code_ok = 1'b0;
        endcase
    end

    assign prbs_inc = events.prbs_err && ctrl_reg[CTRL_PRBS_EN_BIT] && events.prbs_locked;
    assign txf_inc = events.tx_framing_err && events.tx_frame_aligned;
    assign rxf_inc = events.rx_framing_err && events.rx_frame_aligned
                     && !(ctrl_reg[CTRL_AIS_INHIBIT_BIT] && events.rx_ais_active);
    assign ndf_inc = pointer_tracking_enable && events.ndf_seen && ndf_code_ok
                     && !events.ndf_from_ais;

    // Saturating or wrapping add, 16 bits
    function automatic logic [W16-1:0] add16(input logic [W16-1:0] v, input logic [3:0] n,
                                             input logic wrap);
        logic [W16:0] s;
        s = {1'b0, v} + {{(W16-3){1'b0}}, n};
        if (s[W16] && !wrap) begin
            add16 = '1;
        end else begin
            add16 = s[W16-1:0];
        end
    endfunction : add16

    function automatic logic [W8-1:0] add8(input logic [W8-1:0] v, input logic n,
                                           input logic wrap);
        if (n && (&v) && !wrap) begin
            add8 = v;
        end else begin
            add8 = v + {{(W8-1){1'b0}}, n};
        end
    endfunction : add8

    // Read clears only in saturating mode; an event in the clearing read is lost
    // to keep the read value and the zero consistent.
    function automatic logic rc(input logic [7:0] i);
        rc = rd_en && !rollover_select && idx == i;
    endfunction : rc

    // ************************************************************
    // Counters
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            b3_cnt_reg <= '0;
            fe_cnt_reg <= '0;
            prbs_cnt_reg <= '0;
            txf_cnt_reg <= '0;
            rxf_cnt_reg <= '0;
        end else if (clear_all_counters) begin
            b3_cnt_reg <= '0;
            fe_cnt_reg <= '0;
            prbs_cnt_reg <= '0;
            txf_cnt_reg <= '0;
            rxf_cnt_reg <= '0;
        end else begin
            // High byte read finishes a 16-bit read
            b3_cnt_reg <= rc(IDX_B3_HI) ? '0
                : add16(b3_cnt_reg, {3'b000, events.b3_parity_err}, rollover_select);
            fe_cnt_reg <= rc(IDX_FE_HI) ? '0 : add16(fe_cnt_reg, fe_inc, rollover_select);
            prbs_cnt_reg <= rc(IDX_PRBS_HI) ? '0
                : add16(prbs_cnt_reg, {3'b000, prbs_inc}, rollover_select);
            txf_cnt_reg <= rc(IDX_TXF_HI) ? '0
                : add16(txf_cnt_reg, {3'b000, txf_inc}, rollover_select);
            rxf_cnt_reg <= rc(IDX_RXF_HI) ? '0
                : add16(rxf_cnt_reg, {3'b000, rxf_inc}, rollover_select);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blk_cnt_reg <= '0;
            pos_cnt_reg <= '0;
            neg_cnt_reg <= '0;
            ndf_cnt_reg <= '0;
        end else if (clear_all_counters) begin
            blk_cnt_reg <= '0;
            pos_cnt_reg <= '0;
            neg_cnt_reg <= '0;
            ndf_cnt_reg <= '0;
        end else begin
            blk_cnt_reg <= rc(IDX_B3_BLK) ? '0
                : add8(blk_cnt_reg, events.b3_block_err, rollover_select);
            pos_cnt_reg <= rc(IDX_POS_JUST) ? '0
                : add8(pos_cnt_reg, events.pos_just, rollover_select);
            neg_cnt_reg <= rc(IDX_NEG_JUST) ? '0
                : add8(neg_cnt_reg, events.neg_just, rollover_select);
            ndf_cnt_reg <= rc(IDX_NDF) ? '0 : add8(ndf_cnt_reg, ndf_inc, rollover_select);
        end
    end

    // ************************************************************
    // High byte snapshot
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hi_hold_reg <= '0;
        end else if (rd_en) begin
            unique case (idx)
                IDX_B3_LO: hi_hold_reg <= b3_cnt_reg[15:8];
                IDX_FE_LO: hi_hold_reg <= fe_cnt_reg[15:8];
                IDX_PRBS_LO: hi_hold_reg <= prbs_cnt_reg[15:8];
                IDX_TXF_LO: hi_hold_reg <= txf_cnt_reg[15:8];
                IDX_RXF_LO: hi_hold_reg <= rxf_cnt_reg[15:8];
                default: hi_hold_reg <= hi_hold_reg;
            endcase
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        unique case (idx)
            IDX_CTRL: rd_byte = ctrl_reg & CTRL_WMASK;
            IDX_B3_LO: rd_byte = b3_cnt_reg[7:0];
            IDX_FE_LO: rd_byte = fe_cnt_reg[7:0];
            IDX_PRBS_LO: rd_byte = prbs_cnt_reg[7:0];
            IDX_TXF_LO: rd_byte = txf_cnt_reg[7:0];
            IDX_RXF_LO: rd_byte = rxf_cnt_reg[7:0];
            IDX_B3_HI, IDX_FE_HI, IDX_PRBS_HI, IDX_TXF_HI, IDX_RXF_HI: rd_byte = hi_hold_reg;
            IDX_B3_BLK: rd_byte = blk_cnt_reg;
            IDX_POS_JUST: rd_byte = pos_cnt_reg;
            IDX_NEG_JUST: rd_byte = neg_cnt_reg;
            IDX_NDF: rd_byte = ndf_cnt_reg;
            IDX_LEAK_LO: rd_byte = leak_offset.magnitude[7:0];
            // Sign in bit 1: 0 = bits to leak, 1 = skipped leaks
            IDX_LEAK_HI: rd_byte = {6'b00_0000, leak_offset.sign, leak_offset.magnitude[8]};
            default: rd_byte = 8'h00;
        endcase
    end

    // Registered so data is stable; psel setup cycle loads it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_clear_self: assert property (@(posedge clk_sys) disable iff (sys_rst)
        clear_all_counters |=> !clear_all_counters && b3_cnt_reg == '0 && ndf_cnt_reg == '0)
        else $error("clear bit did not self clear or counters not zero");
    a_read_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rd_en && idx == IDX_B3_BLK && !rollover_select && !clear_all_counters
        |=> blk_cnt_reg == '0)
        else $error("saturating read did not clear");
    a_read_keeps: assert property (@(posedge clk_sys) disable iff (sys_rst)
        rd_en && idx == IDX_B3_BLK && rollover_select && !clear_all_counters
        && !events.b3_block_err |=> $stable(blk_cnt_reg))
        else $error("roll-over read changed counter");
    a_sat_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (&blk_cnt_reg) && !rollover_select && !rc(IDX_B3_BLK) && !clear_all_counters
        |=> &blk_cnt_reg)
        else $error("saturated counter moved");
    a_wrap_over: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (&blk_cnt_reg) && rollover_select && events.b3_block_err && !clear_all_counters
        |=> blk_cnt_reg == '0)
        else $error("counter did not wrap");
    a_fe_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl_reg[CTRL_FAR_END_BLOCK_BIT] && events.far_end_valid
        && events.far_end_count > FE_MAX && !clear_all_counters && !rc(IDX_FE_HI)
        |=> $stable(fe_cnt_reg))
        else $error("far-end value out of range added");
    a_ndf_ais: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pointer_tracking_enable && events.ndf_seen && events.ndf_from_ais
        && !clear_all_counters && !rc(IDX_NDF) |=> $stable(ndf_cnt_reg))
        else $error("ais transition flag counted");
    a_prbs_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !events.prbs_locked && !clear_all_counters && !rc(IDX_PRBS_HI) |=> $stable(prbs_cnt_reg))
        else $error("prbs counted while unlocked");
    a_tx_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !events.tx_frame_aligned && !clear_all_counters && !rc(IDX_TXF_HI)
        |=> $stable(txf_cnt_reg))
        else $error("tx framing counted before alignment");
    a_rx_inhibit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_reg[CTRL_AIS_INHIBIT_BIT] && events.rx_ais_active && !clear_all_counters
        && !rc(IDX_RXF_HI) |=> $stable(rxf_cnt_reg))
        else $error("rx framing counted during ais");

    // ************************************************************
    // Increment checks
    // ************************************************************
    // Held below all-ones, far-end add below the top bit; the hold check covers saturation of blk_cnt_reg only
    a_b3_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        events.b3_parity_err && !(&b3_cnt_reg) && !clear_all_counters && !rc(IDX_B3_HI)
        |=> b3_cnt_reg == $past(b3_cnt_reg) + 1'b1)
        else $error("b3 parity error not counted");
    a_fe_add: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !ctrl_reg[CTRL_FAR_END_BLOCK_BIT] && events.far_end_valid
        && events.far_end_count >= FE_MIN && events.far_end_count <= FE_MAX
        && !fe_cnt_reg[W16-1] && !clear_all_counters && !rc(IDX_FE_HI)
        |=> fe_cnt_reg == $past(fe_cnt_reg) + $past(events.far_end_count))
        else $error("far-end count not added");
    a_fe_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ctrl_reg[CTRL_FAR_END_BLOCK_BIT] && events.far_end_block_err && !(&fe_cnt_reg)
        && !clear_all_counters && !rc(IDX_FE_HI)
        |=> fe_cnt_reg == $past(fe_cnt_reg) + 1'b1)
        else $error("errored block not counted");
    a_blk_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        events.b3_block_err && !(&blk_cnt_reg) && !clear_all_counters && !rc(IDX_B3_BLK)
        |=> blk_cnt_reg == $past(blk_cnt_reg) + 1'b1)
        else $error("b3 block error not counted");
    a_pos_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        events.pos_just && !(&pos_cnt_reg) && !clear_all_counters && !rc(IDX_POS_JUST)
        |=> pos_cnt_reg == $past(pos_cnt_reg) + 1'b1)
        else $error("positive step not counted");
    a_neg_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        events.neg_just && !(&neg_cnt_reg) && !clear_all_counters && !rc(IDX_NEG_JUST)
        |=> neg_cnt_reg == $past(neg_cnt_reg) + 1'b1)
        else $error("negative step not counted");
    a_ndf_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pointer_tracking_enable && events.ndf_seen && ndf_code_ok && !events.ndf_from_ais
        && !(&ndf_cnt_reg) && !clear_all_counters && !rc(IDX_NDF)
        |=> ndf_cnt_reg == $past(ndf_cnt_reg) + 1'b1)
        else $error("new data flag not counted");
    a_ndf_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !pointer_tracking_enable && !clear_all_counters && !rc(IDX_NDF)
        |=> $stable(ndf_cnt_reg))
        else $error("new data flag counted without tracking");

    // ************************************************************
    // Read path checks
    // ************************************************************
    // Leak offset is read live, so its two bytes may come from different counts
    sequence s_b3_low_read;
        rd_en && idx == IDX_B3_LO;
    endsequence

    sequence s_b3_high_clear;
        rd_en && idx == IDX_B3_HI && !rollover_select && !clear_all_counters;
    endsequence

    a_hi_snap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_b3_low_read
        |=> hi_hold_reg == $past(b3_cnt_reg[15:8]))
        else $error("high byte not captured on low read");
    a_hi_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_b3_high_clear
        |=> b3_cnt_reg == '0)
        else $error("high byte read did not clear");
    a_leak_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
        psel && !penable && idx == IDX_LEAK_LO
        |=> prdata[7:0] == $past(leak_offset.magnitude[7:0]))
        else $error("leak offset low byte wrong");
    a_leak_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
        psel && !penable && idx == IDX_LEAK_HI
        |=> prdata[7:0] == {6'b00_0000, $past(leak_offset.sign), $past(leak_offset.magnitude[8])}
        && prdata[31:8] == 24'h00_0000)
        else $error("leak offset high byte wrong");
    // Clear bit must never read back as one
    a_clear_reads_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        psel && !penable && idx == IDX_CTRL
        |=> prdata[CTRL_CLEAR_BIT] == 1'b0)
        else $error("clear bit read back as one");
    // Control writes land at the access edge only
    a_ctrl_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_en && idx == IDX_CTRL
        |=> ctrl_reg == $past(pwdata[7:0]))
        else $error("control write did not land");
endmodule : ppc_counters

`default_nettype wire

/* File: rtl/ppc_pkg.sv */
// Purpose: Constants and types for the path performance counter bank
// Assumes: APB slave, 32-bit data, one byte-wide register per aligned word
// Notes: Printed offsets are register indexes; byte address is four times the index
package ppc_pkg;
    // ************************************************************
    // Register indexes
    // ************************************************************
    localparam logic [7:0] IDX_CTRL = 8'h13;
    localparam logic [7:0] IDX_B3_LO = 8'h40;
    localparam logic [7:0] IDX_B3_HI = 8'h41;
    localparam logic [7:0] IDX_FE_LO = 8'h42;
    localparam logic [7:0] IDX_FE_HI = 8'h43;
    localparam logic [7:0] IDX_PRBS_LO = 8'h44;
    localparam logic [7:0] IDX_PRBS_HI = 8'h45;
    localparam logic [7:0] IDX_TXF_LO = 8'h46;
    localparam logic [7:0] IDX_TXF_HI = 8'h47;
    localparam logic [7:0] IDX_RXF_LO = 8'h48;
    localparam logic [7:0] IDX_RXF_HI = 8'h49;
    localparam logic [7:0] IDX_B3_BLK = 8'h4a;
    localparam logic [7:0] IDX_POS_JUST = 8'h4b;
    localparam logic [7:0] IDX_NEG_JUST = 8'h4c;
    localparam logic [7:0] IDX_NDF = 8'h4d;
    localparam logic [7:0] IDX_LEAK_LO = 8'h4e;
    localparam logic [7:0] IDX_LEAK_HI = 8'h4f;
    localparam int ADDR_LSB = 2;
    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int CTRL_ROLLOVER_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int CTRL_FAR_END_BLOCK_BIT = 2;
    localparam int CTRL_PRBS_EN_BIT = 3;
    localparam int CTRL_AIS_INHIBIT_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h1d;
    localparam logic [3:0] FE_MAX = 4'h8;
    localparam logic [3:0] FE_MIN = 4'h1;
    // ************************************************************
    // Event carrier
    // ************************************************************
    typedef struct packed {
        logic b3_parity_err;
        logic far_end_valid;
        logic [3:0] far_end_count;
        logic far_end_block_err;
        logic prbs_err;
        logic prbs_locked;
        logic tx_frame_aligned;
        logic tx_framing_err;
        logic rx_frame_aligned;
        logic rx_framing_err;
        logic rx_ais_active;
        logic b3_block_err;
        logic pos_just;
        logic neg_just;
        logic ndf_seen;
        logic [3:0] new_data_flag_code;
        logic ndf_from_ais;
    } ppc_event_type;
    typedef struct packed {
        logic sign;
        logic [8:0] magnitude;
    } ppc_leak_type;
endpackage : ppc_pkg

/* File: dv/ppc_cpu_model.sv */
// Purpose: Processor model driving the APB port
// Assumes: pready sampled at rising edges
// Notes: Waits for pready with no cycle count; bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module ppc_cpu_model (
    // Clock
    input wire logic clk_sys,
    // APB
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; software reads low byte before high byte
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale data would hide a late write; invert it
        pwdata <= ~wd;
    endtask : xfer
endmodule : ppc_cpu_model
`default_nettype wire

/* File: dv/test_path_performance_counters.sv */
// Purpose: Self-checking bench for the performance counter bank
// Assumes: Zero-wait APB, one-cycle event pulses
// Notes: 16-bit roll-over is not run; it would take too many cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_path_performance_counters
    import ppc_pkg::*;
;
    logic clk_sys;
    logic sys_rst;
    logic psel, penable, pwrite, pready, pslverr, pte;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    ppc_event_type ev, base, e;
    ppc_leak_type leak;
    logic [3:0] codes [5] = '{4'h9, 4'h1, 4'hd, 4'hb, 4'h8};
    int errors = 0;
    int n_checks = 0;

    ppc_counters i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(ev), .pointer_tracking_enable(pte), .leak_offset(leak));
    ppc_cpu_model i_cpu (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        i_cpu.xfer(1'b1, idx, v, d);
    endtask : wr
    task automatic rc(input logic [7:0] idx, input logic [7:0] x);
        i_cpu.xfer(1'b0, idx, 32'h0000_0000, d);
        `CHK(d, {24'h00_0000, x})
        `CHK({pready, pslverr}, 2'b10)
    endtask : rc
    task automatic fire(input ppc_event_type x, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ev <= ppc_event_type'(base | x);
            @(posedge clk_sys);
            ev <= base;
        end
    endtask : fire
    task automatic t_reset();
        for (int i = 'h40; i <= 'h4d; i++) rc(8'(i), 8'h00);
        rc(IDX_CTRL, CTRL_RESET);
        rc(8'h20, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_sat();
        e = '0;
        e.b3_parity_err = 1'b1;
        fire(e, 3);
        rc(IDX_B3_LO, 8'h03);
        rc(IDX_B3_HI, 8'h00);
        rc(IDX_B3_LO, 8'h00);
        fire(e, 257);
        rc(IDX_B3_LO, 8'h01);
        fire(e, 1);
        rc(IDX_B3_HI, 8'h01);
        rc(IDX_B3_LO, 8'h00);
        e = '0;
        e.b3_block_err = 1'b1;
        fire(e, 257);
        rc(IDX_B3_BLK, 8'hff);
        rc(IDX_B3_BLK, 8'h00);
        $display("saturate test done");
    endtask : t_sat
    task automatic t_roll();
        wr(IDX_CTRL, 32'h0000_0001);
        fire(e, 257);
        rc(IDX_B3_BLK, 8'h01);
        rc(IDX_B3_BLK, 8'h01);
        wr(IDX_CTRL, 32'h0000_0003);
        rc(IDX_B3_BLK, 8'h00);
        rc(IDX_CTRL, 8'h01);
        wr(IDX_CTRL, 32'h0000_0000);
        $display("roll-over test done");
    endtask : t_roll
    task automatic t_far();
        e = '0;
        e.far_end_valid = 1'b1;
        foreach (codes[i]) begin
            e.far_end_count = 4'(i * 3 + 5);
            fire(e, 1);
        end
        rc(IDX_FE_LO, 8'h0e);
        rc(IDX_FE_HI, 8'h00);
        wr(IDX_CTRL, 32'h0000_0004);
        e = '0;
        e.far_end_block_err = 1'b1;
        fire(e, 2);
        rc(IDX_FE_LO, 8'h02);
        rc(IDX_FE_HI, 8'h00);
        $display("far-end test done");
    endtask : t_far
    task automatic t_gate();
        wr(IDX_CTRL, 32'h0000_0000);
        e = '0;
        e.prbs_err = 1'b1;
        e.tx_framing_err = 1'b1;
        e.rx_framing_err = 1'b1;
        base.rx_ais_active = 1'b1;
        fire(e, 1);
        base.prbs_locked = 1'b1;
        base.tx_frame_aligned = 1'b1;
        base.rx_frame_aligned = 1'b1;
        fire(e, 1);
        wr(IDX_CTRL, 32'h0000_0018);
        fire(e, 1);
        base.rx_ais_active = 1'b0;
        fire(e, 2);
        rc(IDX_PRBS_LO, 8'h03);
        rc(IDX_PRBS_HI, 8'h00);
        rc(IDX_TXF_LO, 8'h04);
        rc(IDX_TXF_HI, 8'h00);
        rc(IDX_RXF_LO, 8'h03);
        rc(IDX_RXF_HI, 8'h00);
        $display("gating test done");
    endtask : t_gate
    task automatic t_ptr();
        e = '0;
        e.pos_just = 1'b1;
        fire(e, 2);
        e = '0;
        e.neg_just = 1'b1;
        fire(e, 3);
        pte <= 1'b1;
        e = '0;
        e.ndf_seen = 1'b1;
        foreach (codes[i]) begin
            e.new_data_flag_code = codes[i];
            fire(e, 1);
        end
        e.ndf_from_ais = 1'b1;
        fire(e, 1);
        pte <= 1'b0;
        e.ndf_from_ais = 1'b0;
        fire(e, 1);
        rc(IDX_POS_JUST, 8'h02);
        rc(IDX_NEG_JUST, 8'h03);
        rc(IDX_NDF, 8'h05);
        leak <= {1'b1, 9'h1a5};
        rc(IDX_LEAK_LO, 8'ha5);
        rc(IDX_LEAK_HI, 8'h03);
        leak <= {1'b0, 9'h03c};
        rc(IDX_LEAK_HI, 8'h00);
        $display("pointer test done");
    endtask : t_ptr
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // Sequence and watchdog
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        pte = 1'b0;
        leak = '0;
        ev = '0;
        base = '0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_sat();
        t_roll();
        t_far();
        t_gate();
        t_ptr();
        complete_run();
    end
    initial begin
        // About seven times the expected run length
        #(25 * 12000);
        errors++;
        complete_run();
    end
endmodule : test_path_performance_counters
`default_nettype wire
